// file: logic/serial_port_four_mode.sv
// Four-mode serial port with an Avalon-MM register slave
`timescale 1ns/10ps
module serial_port_four_mode
	import serial_port_pkg::*;
(
	input wire logic i_mclk, // Core clock
	input wire logic i_rst, // Asynchronous reset, active high
	input wire logic [3:0] i_address, // Avalon byte address
	input wire logic i_read, // Avalon read request
	input wire logic i_write, // Avalon write request
	input wire logic [31:0] i_writedata, // Avalon write data
	input wire logic [3:0] i_byteenable, // Avalon byte enables
	output logic [31:0] o_readdata, // Avalon read data
	output logic o_waitrequest, // Avalon wait request
	input wire logic i_t1_ovf, // Timer 1 overflow pulse, same clock
	input wire logic i_t2_ovf, // Timer 2 overflow pulse, same clock
	input wire logic i_rxd, // Receive / mode 0 data pin input
	output logic o_rxd, // Mode 0 data pin output
	output logic o_rxd_oe, // Mode 0 data pin output enable
	output logic o_txd // Transmit pin or mode 0 shift clock
);

	state_s s;
	state_s next_s;
	logic [2:0] tx_cfg;
	logic [2:0] rx_cfg;
	logic tx_tick;
	logic rx_tick;
	logic tx_bit;
	logic rx_bit;
	logic wr_fire;
	logic nine;
	logic ninth;
	logic fall;
	logic [7:0] wd;

	// Tick source per direction: {event, prescale limit}
	function automatic logic [2:0] tick_cfg(
		input logic [1:0] mode,
		input logic dbl,
		input logic sel_t2,
		input logic t1,
		input logic t2
	);
		logic [2:0] r;
		if (mode == MODE_FIXED9) begin
			r = {1'b1, dbl ? PRE_M2_FAST : PRE_M2_SLOW};
		end else if (sel_t2) begin
			r = {t2, PRE_T2};
		end else begin
			r = {t1, dbl ? PRE_T1_FAST : PRE_T1_SLOW};
		end
		return r;
	endfunction : tick_cfg

	// Next-state logic for the whole port
	always_comb begin
		next_s = s;
		wd = i_writedata[7:0];
		nine = s.mode[1];
		ninth = 1'b0;
		// Sample-tick generation, one prescaler per direction
		tx_cfg = tick_cfg(s.mode, s.baud_double, s.tx_t2, i_t1_ovf, i_t2_ovf);
		rx_cfg = tick_cfg(s.mode, s.baud_double, s.rx_t2, i_t1_ovf, i_t2_ovf);
		tx_tick = tx_cfg[2] && (s.tx_pre == tx_cfg[1:0]);
		rx_tick = rx_cfg[2] && (s.rx_pre == rx_cfg[1:0]);
		tx_bit = tx_tick && (s.tx_div == DIV_LAST);
		rx_bit = rx_tick && (s.rx_div == DIV_LAST);
		if (tx_cfg[2]) begin
			next_s.tx_pre = tx_tick ? 2'h0 : s.tx_pre + 2'h1;
		end
		if (rx_cfg[2]) begin
			next_s.rx_pre = rx_tick ? 2'h0 : s.rx_pre + 2'h1;
		end
		if (tx_tick) begin
			next_s.tx_div = s.tx_div + 4'h1;
		end
		if (rx_tick) begin
			next_s.rx_div = s.rx_div + 4'h1;
		end

		// Bus slave: one wait cycle, then the access completes
		next_s.ack = (i_read || i_write) && !s.ack;
		wr_fire = i_write && s.ack && i_byteenable[0];
		if (i_read && !s.ack) begin
			case (i_address)
				OFS_CTRL: next_s.rdata = {24'h000000, s.mode, s.addr_filter_enable,
					s.rx_enable, s.tx_ninth_bit, s.rx_ninth_bit, s.tx_done_flag,
					s.rx_full_flag};
				OFS_DATA: next_s.rdata = {24'h000000, s.rx_buf};
				OFS_BAUD: next_s.rdata = {29'h00000000, s.tx_t2, s.rx_t2, s.baud_double};
				default: next_s.rdata = 32'h00000000;
			endcase
		end
		// Software register writes; flag writes are overridden by hardware sets below
		if (wr_fire && i_address == OFS_CTRL) begin
			next_s.mode = wd[CTRL_MODE_HI:CTRL_MODE_LO];
			next_s.addr_filter_enable = wd[CTRL_FILTER];
			next_s.rx_enable = wd[CTRL_RX_EN];
			next_s.tx_ninth_bit = wd[CTRL_TX_NINTH];
			next_s.rx_ninth_bit = wd[CTRL_RX_NINTH];
			next_s.tx_done_flag = wd[CTRL_TX_DONE];
			next_s.rx_full_flag = wd[CTRL_RX_FULL];
		end
		if (wr_fire && i_address == OFS_BAUD) begin
			next_s.baud_double = wd[BAUD_DOUBLE];
			next_s.rx_t2 = wd[BAUD_RX_T2];
			next_s.tx_t2 = wd[BAUD_TX_T2];
		end

		// Async transmitter: each bit lasts sixteen sample ticks
		unique case (s.tx_st)
			TX_IDLE: begin
				next_s.txd = 1'b1;
			end
			TX_WAIT, TX_SHIFT: begin
				if (tx_bit) begin
					if (s.tx_bits == 4'h0) begin
						next_s.tx_st = TX_IDLE;
						next_s.txd = 1'b1;
					end else begin
						next_s.tx_st = TX_SHIFT;
						next_s.txd = s.tx_sh[0];
						next_s.tx_sh = {1'b1, s.tx_sh[10:1]};
						next_s.tx_bits = s.tx_bits - 4'h1;
						if (s.tx_bits == 4'h1) begin
							next_s.tx_done_flag = 1'b1;
						end
					end
				end
			end
		endcase

		// Mode 0 shifter; half duplex, one bit per twelve core clocks
		unique case (s.m0_st)
			M0_IDLE: begin
				if (s.mode == MODE_SHIFT && s.rx_enable && !s.rx_full_flag) begin
					next_s.m0_st = M0_RX;
					next_s.m0_ph = 4'h0;
					next_s.m0_cnt = 4'h0;
				end
			end
			M0_TX, M0_RX: begin
				next_s.m0_ph = s.m0_ph + 4'h1;
				// Sample on the rising shift-clock edge
				if (s.m0_st == M0_RX && s.m0_ph == M0_HALF) begin
					next_s.m0_sh = {s.rxd_s2, s.m0_sh[7:1]};
				end
				if (s.m0_ph == M0_LAST) begin
					next_s.m0_ph = 4'h0;
					next_s.m0_cnt = s.m0_cnt + 4'h1;
					if (s.m0_st == M0_TX) begin
						next_s.m0_sh = {1'b0, s.m0_sh[7:1]};
					end
					if (s.m0_cnt == M0_BIT_LAST) begin
						next_s.m0_st = M0_IDLE;
						if (s.m0_st == M0_TX) begin
							next_s.tx_done_flag = 1'b1;
						end else begin
							next_s.rx_full_flag = 1'b1;
							next_s.rx_buf = s.m0_sh;
						end
					end
				end
				// Dropping receive enable abandons a mode 0 receive
				if (s.m0_st == M0_RX && !s.rx_enable) begin
					next_s.m0_st = M0_IDLE;
				end
			end
			default: begin
				next_s.m0_st = M0_IDLE;
			end
		endcase

		// Async receiver with two-stage pin synchroniser
		next_s.rxd_s1 = i_rxd;
		next_s.rxd_s2 = s.rxd_s1;
		next_s.rxd_q = s.rxd_s2;
		fall = s.rxd_q && !s.rxd_s2;
		unique case (s.rx_st)
			RX_IDLE: begin
				if (fall && s.rx_enable && s.mode != MODE_SHIFT) begin
					next_s.rx_st = RX_START;
					next_s.rx_div = 4'h0;
				end
			end
			RX_START: begin
				// A glitch shorter than half a bit is rejected here
				if (rx_tick && s.rx_div == RX_MID) begin
					next_s.rx_div = 4'h0;
					next_s.rx_cnt = 4'h0;
					next_s.rx_st = s.rxd_s2 ? RX_IDLE : RX_DATA;
				end
			end
			RX_DATA: begin
				if (rx_bit) begin
					next_s.rx_sh = {s.rxd_s2, s.rx_sh[8:1]};
					next_s.rx_cnt = s.rx_cnt + 4'h1;
					if (s.rx_cnt == (nine ? RX_LAST9 : RX_LAST8)) begin
						next_s.rx_st = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_bit) begin
					next_s.rx_st = RX_IDLE;
					ninth = nine ? s.rx_sh[8] : s.rxd_s2;
					// Unread data is kept; the new frame is the one lost
					if (!s.rx_full_flag && (!s.addr_filter_enable || ninth)) begin
						next_s.rx_buf = nine ? s.rx_sh[7:0] : s.rx_sh[8:1];
						next_s.rx_ninth_bit = ninth;
						next_s.rx_full_flag = 1'b1;
					end
				end
			end
		endcase
		if (!s.rx_enable) begin
			next_s.rx_st = RX_IDLE;
		end

		// Data write starts a transmission; it wins over any frame in flight
		if (wr_fire && i_address == OFS_DATA) begin
			if (s.mode == MODE_SHIFT) begin
				next_s.m0_st = M0_TX;
				next_s.m0_sh = wd;
				next_s.m0_ph = 4'h0;
				next_s.m0_cnt = 4'h0;
			end else begin
				next_s.tx_st = TX_WAIT;
				next_s.tx_sh = {1'b1, (s.mode == MODE_ASYNC8) ? 1'b1 : s.tx_ninth_bit,
					wd, 1'b0};
				next_s.tx_bits = (s.mode == MODE_ASYNC8) ? FRAME_10 : FRAME_11;
			end
		end

		// Transmit pin: shift clock in mode 0, idles high between transfers
		next_s.pin_txd = (next_s.mode == MODE_SHIFT) ?
			!((next_s.m0_st != M0_IDLE) && (next_s.m0_ph < M0_HALF)) : next_s.txd;
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			s <= '0;
			s.txd <= 1'b1;
			s.pin_txd <= 1'b1;
			s.rxd_s1 <= 1'b1;
			s.rxd_s2 <= 1'b1;
			s.rxd_q <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Outputs from the state record; wait request and the data-pin enable are combinational
	assign o_waitrequest = (i_read || i_write) && !s.ack;
	assign o_readdata = s.rdata;
	assign o_txd = s.pin_txd;
	assign o_rxd = s.m0_sh[0];
	assign o_rxd_oe = (s.m0_st == M0_TX);

endmodule : serial_port_four_mode

// file: logic/serial_port_pkg.sv
// Constants, states and the state record of the four-mode serial port
package serial_port_pkg;
	// Register byte offsets on the bus
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_DATA = 4'h4;
	localparam logic [3:0] OFS_BAUD = 4'h8;
	// Control register field positions
	localparam int CTRL_MODE_HI = 7;
	localparam int CTRL_MODE_LO = 6;
	localparam int CTRL_FILTER = 5;
	localparam int CTRL_RX_EN = 4;
	localparam int CTRL_TX_NINTH = 3;
	localparam int CTRL_RX_NINTH = 2;
	localparam int CTRL_TX_DONE = 1;
	localparam int CTRL_RX_FULL = 0;
	// Baud configuration field positions
	localparam int BAUD_DOUBLE = 0;
	localparam int BAUD_RX_T2 = 1;
	localparam int BAUD_TX_T2 = 2;
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] BAUD_RESET = 3'h0;
	// Mode select codes
	localparam logic [1:0] MODE_SHIFT = 2'h0;
	localparam logic [1:0] MODE_ASYNC8 = 2'h1;
	localparam logic [1:0] MODE_FIXED9 = 2'h2;
	localparam logic [1:0] MODE_VAR9 = 2'h3;
	// Mode 0: twelve core clocks per bit, clock low for the first half
	localparam logic [3:0] M0_HALF = 4'h6;
	localparam logic [3:0] M0_LAST = 4'hb;
	localparam logic [3:0] M0_BIT_LAST = 4'h7;
	// Prescaler limits: events per sixteenth of a bit, minus one
	localparam logic [1:0] PRE_M2_SLOW = 2'h3;
	localparam logic [1:0] PRE_M2_FAST = 2'h1;
	localparam logic [1:0] PRE_T1_SLOW = 2'h1;
	localparam logic [1:0] PRE_T1_FAST = 2'h0;
	localparam logic [1:0] PRE_T2 = 2'h0;
	// Sixteen sample ticks per bit
	localparam logic [3:0] DIV_LAST = 4'hf;
	localparam logic [3:0] RX_MID = 4'h7;
	// Frame lengths in bits and last data-bit indices
	localparam logic [3:0] FRAME_10 = 4'ha;
	localparam logic [3:0] FRAME_11 = 4'hb;
	localparam logic [3:0] RX_LAST8 = 4'h7;
	localparam logic [3:0] RX_LAST9 = 4'h8;

	typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tx_state_e;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
	typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} m0_state_e;

	typedef struct packed {
		logic [1:0] mode;
		logic addr_filter_enable;
		logic rx_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_full_flag;
		logic baud_double;
		logic rx_t2;
		logic tx_t2;
		logic [7:0] rx_buf;
		tx_state_e tx_st;
		logic [10:0] tx_sh;
		logic [3:0] tx_bits;
		logic [3:0] tx_div;
		logic [1:0] tx_pre;
		logic txd;
		logic pin_txd;
		m0_state_e m0_st;
		logic [3:0] m0_ph;
		logic [3:0] m0_cnt;
		logic [7:0] m0_sh;
		rx_state_e rx_st;
		logic [3:0] rx_div;
		logic [3:0] rx_cnt;
		logic [8:0] rx_sh;
		logic [1:0] rx_pre;
		logic rxd_s1;
		logic rxd_s2;
		logic rxd_q;
		logic ack;
		logic [31:0] rdata;
	} state_s;
endpackage : serial_port_pkg

// file: tb/serial_node.sv
// Remote serial node: drives the receive line, captures frames
`timescale 1ns/10ps
module serial_node (
	input wire logic i_clk, // Clock
	input wire logic i_line, // From port
	output logic o_line // To port
);
	// Mark level between frames
	initial o_line = 1'b1;
	// Bits LSB first, start low, stop high
	task automatic send(input logic [10:0] f, input int n, input int per);
		for (int k = 0; k < n; k++) begin
			o_line <= f[k];
			repeat (per) @(posedge i_clk);
		end
		o_line <= 1'b1;
	endtask : send
	// Bounded wait for a start edge, then sample bit centres
	task automatic grab(input int n, input int per, output logic [10:0] f);
		int w;
		w = 0;
		f = 11'h7ff;
		while (i_line && w < 4000) begin
			@(posedge i_clk);
			w++;
		end
		repeat (per / 2) @(posedge i_clk);
		for (int k = 0; k < n; k++) begin
			f[k] = i_line;
			repeat (per) @(posedge i_clk);
		end
	endtask : grab
endmodule : serial_node

// file: tb/serial_port_four_mode_test.sv
// Self-checking bench for the four-mode serial port
`timescale 1ns/10ps
module serial_port_four_mode_test
	import serial_port_pkg::*;
;
	logic i_mclk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_address = 4'h0;
	logic i_read = 1'b0;
	logic i_write = 1'b0;
	logic [31:0] i_writedata = 32'h0;
	logic [31:0] o_readdata;
	logic o_waitrequest, o_rxd, o_rxd_oe, o_txd, rxd, t;
	logic t1 = 1'b0;
	logic t2 = 1'b0;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	int k;
	logic [10:0] f;
	logic [7:0] d;
	// 250 MHz clock
	always #2 i_mclk = ~i_mclk;
	serial_port_four_mode DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address),
		.i_read(i_read), .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'h1),
		.o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .i_t1_ovf(t1),
		.i_t2_ovf(t2), .i_rxd(rxd), .o_rxd(o_rxd), .o_rxd_oe(o_rxd_oe), .o_txd(o_txd));
	serial_node NODE (.i_clk(i_mclk), .i_line(o_txd), .o_line(rxd));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask : chk
	// Request held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
		@(posedge i_mclk);
		i_write <= w;
		i_read <= !w;
		i_address <= a;
		i_writedata <= {24'h0, v};
		do @(posedge i_mclk); while (o_waitrequest);
		d = o_readdata[7:0];
		i_write <= 1'b0;
		i_read <= 1'b0;
	endtask : bus
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(d, e);
	endtask : rd
	// Run needs a few thousand cycles; a hang is cut far above this
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(OFS_CTRL, CTRL_RESET);
		rd(4'hc, 8'h00);
		// Mode 2 doubled: bit is 16 ticks of 2 clocks
		bus(1'b1, OFS_BAUD, 8'h01);
		bus(1'b1, OFS_CTRL, 8'h98);
		bus(1'b1, OFS_DATA, 8'ha5);
		NODE.grab(11, 32, f);
		chk(f[8:1], 8'ha5);
		chk({5'h0, f[10:9], f[0]}, 8'h06);
		rd(OFS_CTRL, 8'h9a);
		NODE.send({2'b11, 8'h3c, 1'b0}, 11, 32);
		rd(OFS_DATA, 8'h3c);
		rd(OFS_CTRL, 8'h9f);
		// Unread byte must survive a second frame
		NODE.send({2'b11, 8'h55, 1'b0}, 11, 32);
		rd(OFS_DATA, 8'h3c);
		bus(1'b1, OFS_CTRL, 8'hb8);
		NODE.send({2'b10, 8'h11, 1'b0}, 11, 32);
		rd(OFS_CTRL, 8'hb8);
		NODE.send({2'b11, 8'h22, 1'b0}, 11, 32);
		rd(OFS_DATA, 8'h22);
		rd(OFS_CTRL, 8'hbd);
		bus(1'b1, OFS_CTRL, 8'ha8);
		NODE.send({2'b11, 8'h33, 1'b0}, 11, 32);
		rd(OFS_CTRL, 8'ha8);
		// Mode 1 on timer 2 both ways, one overflow per clock: 16 clocks a bit
		t2 <= 1'b1;
		bus(1'b1, OFS_BAUD, 8'h06);
		bus(1'b1, OFS_CTRL, 8'h50);
		bus(1'b1, OFS_DATA, 8'h3c);
		NODE.grab(10, 16, f);
		chk(f[8:1], 8'h3c);
		chk({6'h00, f[9], f[0]}, 8'h02);
		NODE.send({2'b11, 8'hc3, 1'b0}, 10, 16);
		rd(OFS_DATA, 8'hc3);
		rd(OFS_CTRL, 8'h57);
		// Filter on: a frame whose stop bit is low must be dropped
		bus(1'b1, OFS_CTRL, 8'h70);
		NODE.send({2'b10, 8'h99, 1'b0}, 10, 16);
		rd(OFS_CTRL, 8'h70);
		rd(OFS_DATA, 8'hc3);
		// Mode 3 transmit on timer 1 doubled: one overflow per sample tick
		t1 <= 1'b1;
		bus(1'b1, OFS_BAUD, 8'h01);
		bus(1'b1, OFS_CTRL, 8'hd8);
		bus(1'b1, OFS_DATA, 8'h81);
		NODE.grab(11, 16, f);
		chk(f[8:1], 8'h81);
		chk({5'h00, f[10:9], f[0]}, 8'h06);
		// Mode 0: take the data pin at each rising shift clock
		bus(1'b1, OFS_CTRL, 8'h00);
		bus(1'b1, OFS_DATA, 8'h5a);
		k = 0;
		t = 1'b1;
		for (int n = 0; n < 300 && k < 8; n++) begin
			@(posedge i_mclk);
			if (o_rxd_oe && o_txd && !t) begin
				f[k] = o_rxd;
				k++;
			end
			t = o_txd;
		end
		chk(f[7:0], 8'h5a);
		while (o_rxd_oe) @(posedge i_mclk);
		rd(OFS_CTRL, 8'h02);
		// Mode 0 receive of the idle-high pin starts as soon as enabled
		bus(1'b1, OFS_CTRL, 8'h10);
		repeat (120) @(posedge i_mclk);
		rd(OFS_CTRL, 8'h11);
		rd(OFS_DATA, 8'hff);
		wrap_up();
	end
endmodule : serial_port_four_mode_test
bind serial_port_four_mode serial_port_props PROPS (.i_mclk(i_mclk), .i_rst(i_rst),
	.i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
	.i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
	.i_t1_ovf(i_t1_ovf), .i_t2_ovf(i_t2_ovf), .i_rxd(i_rxd), .o_rxd(o_rxd),
	.o_rxd_oe(o_rxd_oe), .o_txd(o_txd));

// file: tb/serial_port_props.sv
// Port assertions for the four-mode serial port
`timescale 1ns/10ps
module serial_port_props
	import serial_port_pkg::*;
(
	input wire logic i_mclk, // Clock
	input wire logic i_rst, // Reset
	input wire logic [3:0] i_address, // Address
	input wire logic i_read, // Read
	input wire logic i_write, // Write
	input wire logic [31:0] i_writedata, // Wdata
	input wire logic [3:0] i_byteenable, // Enables
	input wire logic [31:0] o_readdata, // Rdata
	input wire logic o_waitrequest, // Wait
	input wire logic i_t1_ovf, // Timer 1
	input wire logic i_t2_ovf, // Timer 2
	input wire logic i_rxd, // Data in
	input wire logic o_rxd, // Data out
	input wire logic o_rxd_oe, // Data enable
	input wire logic o_txd // Line or clock
);
	logic [1:0] mode_sh;
	logic [7:0] oe_len;
	// Shadow the mode from completed writes; count enable length
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			mode_sh <= MODE_SHIFT;
			oe_len <= 8'h00;
		end else begin
			if (i_write && !o_waitrequest && i_address == OFS_CTRL && i_byteenable[0]) begin
				mode_sh <= i_writedata[7:6];
			end
			oe_len <= o_rxd_oe ? oe_len + 8'h01 : 8'h00;
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	// One shift clock period: six low, six high
	sequence s_low6; (!o_txd)[*6]; endsequence
	sequence s_high6; o_txd[*6]; endsequence
	chk_wait_one:
	assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest) else $error("slow");
	chk_upper_zero:
	assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0) else $error("upper");
	chk_ctrl_mode:
	assert property (i_read && !o_waitrequest && i_address == OFS_CTRL
		|-> o_readdata[7:6] == mode_sh) else $error("mode");
	chk_oe_mode0:
	assert property (o_rxd_oe |-> mode_sh == MODE_SHIFT) else $error("oe mode");
	chk_oe_len:
	assert property ($fell(o_rxd_oe) |-> oe_len == 8'h60) else $error("oe length");
	chk_m0_pulse:
	assert property (o_rxd_oe && $fell(o_txd) |-> s_low6 ##1 s_high6) else $error("pulse");
	chk_m0_hold:
	assert property (o_rxd_oe && o_txd && $past(o_txd) |-> $stable(o_rxd)) else $error("hold");
	chk_reset_idle:
	assert property ($fell(i_rst) |-> o_txd && !o_rxd_oe) else $error("idle");
endmodule : serial_port_props
